// ===== pkg/imt_defs.vh
`ifndef IMT_DEFS_VH
`define IMT_DEFS_VH

// Register byte offsets inside one channel window
`define IMT_OFS_RUN        4'h0
`define IMT_OFS_CSR        4'h4
`define IMT_OFS_CNT        4'h8
`define IMT_OFS_LIM        4'hC
// Channel window stride is one address bit above the window
`define IMT_CH_BIT         4

// Run register field
`define IMT_RUN_BIT        0
// Control/status fields
`define IMT_CSR_FLAG_BIT   7
`define IMT_CSR_REQ_HI     5
`define IMT_CSR_REQ_LO     4
`define IMT_CSR_TICK_HI    1
`define IMT_CSR_TICK_LO    0

// Reset values
`define IMT_RST_RUN        16'h0000
`define IMT_RST_CSR        16'h0000
`define IMT_RST_CNT        16'h0000
`define IMT_RST_LIM        16'hFFFF

// Request-select encodings
`define IMT_REQ_NONE       2'b00
`define IMT_REQ_DMA        2'b01
`define IMT_REQ_IRQ        2'b10
`define IMT_REQ_BAD        2'b11

// Tick dividers of the peripheral clock
`define IMT_DIV_A          4
`define IMT_DIV_B          8
`define IMT_DIV_C          16
`define IMT_DIV_D          64
// Prescaler width that covers the largest divider
`define IMT_PRE_W          6

// AXI response codes
`define IMT_RESP_OKAY      2'b00
`define IMT_RESP_SLVERR    2'b10

`endif

// ===== hdl/imt_prescale.v
`timescale 1ns/100ps
`default_nettype none

module imt_prescale #(
  parameter PRE_W = 6
) (
  // Clock and control
  input  wire             mclk_i,
  input  wire             rst_b_i,
  input  wire             ce_i,
  // Tick pulses for /4, /8, /16, /64
  output wire [3:0]       tick_o
);

  reg  [PRE_W-1:0] pre_r;   // Free-running divider
  wire [PRE_W-1:0] pre_nxt; // Next divider value

  assign pre_nxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};

  // Divider runs while the clock is enabled
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pre_r <= {PRE_W{1'b0}};
    end else if (ce_i) begin
      pre_r <= pre_nxt;
    end
  end

  // One-cycle pulse when the low bits wrap; shared by both channels
  assign tick_o[0] = ce_i & (&pre_r[1:0]);
  assign tick_o[1] = ce_i & (&pre_r[2:0]);
  assign tick_o[2] = ce_i & (&pre_r[3:0]);
  assign tick_o[3] = ce_i & (&pre_r[5:0]);

endmodule // imt_prescale

`default_nettype wire

// ===== hdl/imt_chan.v
`timescale 1ns/100ps
`default_nettype none
`include "imt_defs.vh"

module imt_chan #(
  parameter CNT_W = 16
) (
  // Clock and control
  input  wire             mclk_i,
  input  wire             rst_b_i,
  input  wire             ce_i,
  // Configuration
  input  wire             run_i,
  input  wire [1:0]       tick_sel_i,
  input  wire [3:0]       tick_i,
  input  wire [CNT_W-1:0] limit_i,
  // Software load of the counter
  input  wire             ld_i,
  input  wire [CNT_W-1:0] ld_val_i,
  // State
  output wire [CNT_W-1:0] cnt_o,
  output wire             match_o
);

  reg  [CNT_W-1:0] cnt_r;   // Interval counter
  reg  [CNT_W-1:0] cnt_nxt; // Next counter value
  wire             tick;    // Selected tick

  assign tick = tick_i[tick_sel_i];

  assign match_o = ce_i & run_i & tick & (cnt_r == limit_i) & ~ld_i;

  // Next value; a software load beats a tick
  always @* begin
    cnt_nxt = cnt_r;
    if (ld_i) begin
      cnt_nxt = ld_val_i;
    end else if (match_o) begin
      cnt_nxt = {CNT_W{1'b0}};
    end else if (run_i && tick) begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Counter store, frozen while clock disabled
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_r <= `IMT_RST_CNT;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt_o = cnt_r;

endmodule // imt_chan

`default_nettype wire

// ===== hdl/imt_top.v
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "imt_defs.vh"

module imt_top #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 16,
  parameter NCH    = 2
) (
  // Clock, reset, clock enable
  input  wire              mclk_i,
  input  wire              rst_b_i,
  input  wire              ce_i,
  // AXI4-Lite write address
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  // AXI4-Lite write response
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  output wire [1:0]        s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  // AXI4-Lite read data
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  // Requests, one per channel
  output wire [NCH-1:0]    irq_o,
  output wire [NCH-1:0]    dma_req_o,
  input  wire [NCH-1:0]    dma_ack_i
);

  // Bus handshake state
  reg                awready_r;   // Address slot free
  reg                wready_r;    // Data slot free
  reg                aw_hold_r;   // Address captured
  reg                w_hold_r;    // Data captured
  reg [ADDR_W-1:0]   aw_addr_r;   // Captured write address
  reg [31:0]         w_data_r;    // Captured write data
  reg [3:0]          w_strb_r;    // Captured byte enables
  reg                bvalid_r;    // Write response pending
  reg [1:0]          bresp_r;     // Write response code
  reg                arready_r;   // Read slot free
  reg                rvalid_r;    // Read data pending
  reg [31:0]         rdata_r;     // Read data
  reg [1:0]          rresp_r;     // Read response code

  // Register state, channels packed side by side
  reg [NCH-1:0]      run_r;       // Run bits
  reg [2*NCH-1:0]    req_sel_r;   // Request select fields
  reg [2*NCH-1:0]    tick_sel_r;  // Tick select fields
  reg [NCH-1:0]      flag_r;      // Sticky match flags
  reg [NCH-1:0]      armed_r;     // Flag read as one since
  reg [CNT_W*NCH-1:0] limit_r;    // Limit registers
  reg [NCH-1:0]      dma_r;       // DMA request lines
  reg [NCH-1:0]      irq_r;       // Interrupt lines

  // Channel interconnect
  wire [3:0]         tick;        // Shared tick pulses
  wire [CNT_W*NCH-1:0] cnt;       // Counter values
  wire [NCH-1:0]     match;       // Match pulses
  reg  [NCH-1:0]     cnt_ld;      // Counter load strobes
  reg  [CNT_W-1:0]   wr_val;      // Byte-merged write value
  reg  [CNT_W-1:0]   wr_old;      // Current value of target
  reg  [31:0]        rd_val;      // Read mux result
  reg                rd_hit;      // Read address mapped

  // Write decode
  wire               wr_fire;     // Both halves present
  wire               wr_hit;      // Write address mapped
  wire               wr_ch;       // Write channel index
  wire [1:0]         wr_reg;      // Write register index
  wire               rd_fire;     // Read address taken
  wire               rd_ch;       // Read channel index
  wire [1:0]         rd_reg;      // Read register index

  // Synthesis unrolls the channel loop below
  integer            i;           // Channel loop index

  // Write acts once both halves are held and no answer is pending
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r & ce_i;
  // Upper address bits must be zero for a hit
  assign wr_hit  = (aw_addr_r[ADDR_W-1:`IMT_CH_BIT+1] == {(ADDR_W-`IMT_CH_BIT-1){1'b0}});
  // Channel from the window bit, register from the word index
  assign wr_ch   = aw_addr_r[`IMT_CH_BIT];
  assign wr_reg  = aw_addr_r[3:2];
  // Read decoded straight off the address bus in its handshake cycle
  assign rd_fire = s_axi_arvalid_i & arready_r & ce_i;
  // Same map as the write side
  assign rd_ch   = s_axi_araddr_i[`IMT_CH_BIT];
  assign rd_reg  = s_axi_araddr_i[3:2];

  // One divider keeps the channels' ticks in step
  // Shared divider feeds both channels
  imt_prescale #(
    .PRE_W   (`IMT_PRE_W)
  ) u_pre (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .tick_o  (tick)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      imt_chan #(
        .CNT_W      (CNT_W)
      ) u_chan (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .ce_i       (ce_i),
        .run_i      (run_r[g]),
        .tick_sel_i (tick_sel_r[2*g +: 2]),
        .tick_i     (tick),
        .limit_i    (limit_r[CNT_W*g +: CNT_W]),
        .ld_i       (cnt_ld[g]),
        // Software counter write
        .ld_val_i   (wr_val),
        .cnt_o      (cnt[CNT_W*g +: CNT_W]),
        .match_o    (match[g])
      );
    end
  endgenerate

  // Old value of the write target, for byte merging
  always @* begin
    wr_old = {CNT_W{1'b0}};
    // Reserved bits merge as zero, so they stay zero
    case (wr_reg)
      2'd0: wr_old[0] = run_r[wr_ch];
      2'd1: begin
        wr_old[`IMT_CSR_FLAG_BIT] = flag_r[wr_ch];
        wr_old[5:4] = req_sel_r[2*wr_ch +: 2];
        wr_old[1:0] = tick_sel_r[2*wr_ch +: 2];
      end
      2'd2: wr_old = cnt[CNT_W*wr_ch +: CNT_W];
      2'd3: wr_old = limit_r[CNT_W*wr_ch +: CNT_W];
      default: wr_old = {CNT_W{1'b0}};
    endcase
  end

  // Byte lanes 0 and 1 carry the 16-bit registers
  always @* begin
    wr_val = wr_old;
    if (w_strb_r[0]) begin
      wr_val[7:0] = w_data_r[7:0];
    end
    if (w_strb_r[1]) begin
      wr_val[15:8] = w_data_r[15:8];
    end
    // Counter load strobe, one channel at a time
    cnt_ld = {NCH{1'b0}};
    if (wr_fire && wr_hit && (wr_reg == 2'd2)) begin
      cnt_ld[wr_ch] = 1'b1;
    end
  end

  // Read mux
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = (s_axi_araddr_i[ADDR_W-1:`IMT_CH_BIT+1] == {(ADDR_W-`IMT_CH_BIT-1){1'b0}});
    case (rd_reg)
      2'd0: rd_val[`IMT_RUN_BIT] = run_r[rd_ch];
      2'd1: begin
        rd_val[`IMT_CSR_FLAG_BIT] = flag_r[rd_ch];
        rd_val[`IMT_CSR_REQ_HI:`IMT_CSR_REQ_LO] = req_sel_r[2*rd_ch +: 2];
        rd_val[`IMT_CSR_TICK_HI:`IMT_CSR_TICK_LO] = tick_sel_r[2*rd_ch +: 2];
      end
      2'd2: rd_val[CNT_W-1:0] = cnt[CNT_W*rd_ch +: CNT_W];
      2'd3: rd_val[CNT_W-1:0] = limit_r[CNT_W*rd_ch +: CNT_W];
      default: rd_val = 32'h0000_0000;
    endcase
    // Unmapped reads return zero
    if (!rd_hit) begin
      rd_val = 32'h0000_0000;
    end
  end

  // Write channel handshake; slots reopen after the response
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `IMT_RESP_OKAY;
    end else if (ce_i) begin
      // Address half; halves may come in either order
      if (s_axi_awvalid_i && awready_r) begin
        awready_r <= 1'b0;
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      // Data half, with its byte enables
      if (s_axi_wvalid_i && wready_r) begin
        wready_r <= 1'b0;
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      // Unmapped writes are dropped but still answered
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? `IMT_RESP_OKAY : `IMT_RESP_SLVERR;
      end
      // Slots reopen only after the answer: one write at a time
      if (bvalid_r && s_axi_bready_i) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read handshake; data registered one edge after address
  // Counter reads show the value before the handshake edge
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `IMT_RESP_OKAY;
    end else if (ce_i) begin
      if (rd_fire) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_val;
        rresp_r   <= rd_hit ? `IMT_RESP_OKAY : `IMT_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready_i) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Register file and request lines
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      run_r      <= {NCH{1'b0}};
      req_sel_r  <= {(2*NCH){1'b0}};
      tick_sel_r <= {(2*NCH){1'b0}};
      flag_r     <= {NCH{1'b0}};
      armed_r    <= {NCH{1'b0}};
      limit_r    <= {NCH{`IMT_RST_LIM}};
      // No request pending after reset
      dma_r      <= {NCH{1'b0}};
      irq_r      <= {NCH{1'b0}};
    end else if (ce_i) begin
      // Each channel alike: write, arm, match, requests
      for (i = 0; i < NCH; i = i + 1) begin
        // Software writes to this channel
        if (wr_fire && wr_hit && (wr_ch == i[0])) begin
          case (wr_reg)
            2'd0: run_r[i] <= wr_val[`IMT_RUN_BIT];
            2'd1: begin
              req_sel_r[2*i +: 2]  <= wr_val[`IMT_CSR_REQ_HI:`IMT_CSR_REQ_LO];
              tick_sel_r[2*i +: 2] <= wr_val[`IMT_CSR_TICK_HI:`IMT_CSR_TICK_LO];
              if (armed_r[i] && !wr_val[`IMT_CSR_FLAG_BIT]) begin
                flag_r[i] <= 1'b0;
              end
              armed_r[i] <= 1'b0;
            end
            // Counter writes reach the channel through cnt_ld
            // A limit below the count matches only after wrap
            2'd3: limit_r[CNT_W*i +: CNT_W] <= wr_val;
            default: ;
          endcase
        end
        // Arm clear when read as one
        if (rd_fire && rd_hit && (rd_ch == i[0]) && (rd_reg == 2'd1) && flag_r[i]) begin
          armed_r[i] <= 1'b1;
        end
        // Match sets flag, wins over clear
        if (match[i]) begin
          flag_r[i] <= 1'b1;
        end
        // Acceptance drops DMA request; new match wins
        if (dma_ack_i[i]) begin
          dma_r[i] <= 1'b0;
        end
        // Prohibited mode 11 raises neither request
        if (match[i] && (req_sel_r[2*i +: 2] == `IMT_REQ_DMA)) begin
          dma_r[i] <= 1'b1;
        end
        // Interrupt tracks flag and mode
        // Registered, so the line lags the flag by a cycle
        irq_r[i] <= flag_r[i] & (req_sel_r[2*i +: 2] == `IMT_REQ_IRQ);
      end
    end
  end

  // Outputs straight from flip-flops
  // Write side
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  // Read side
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;
  // Request lines; both are levels, not pulses
  assign irq_o           = irq_r;
  assign dma_req_o       = dma_r;

endmodule // imt_top

`default_nettype wire

// ===== test/imt_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "imt_defs.vh"

module imt_props #(
  parameter NCH = 2
) (
  // Clock and control
  input wire logic           mclk_i,
  input wire logic           rst_b_i,
  input wire logic           ce_i,
  // Bus handshakes
  input wire logic           s_axi_awready_o,
  input wire logic           s_axi_wready_o,
  input wire logic           s_axi_bvalid_o,
  input wire logic           s_axi_bready_i,
  input wire logic [1:0]     s_axi_bresp_o,
  input wire logic           s_axi_arvalid_i,
  input wire logic           s_axi_arready_o,
  input wire logic           s_axi_rvalid_o,
  input wire logic           s_axi_rready_i,
  input wire logic [31:0]    s_axi_rdata_o,
  // Requests
  input wire logic [NCH-1:0] irq_o,
  input wire logic [NCH-1:0] dma_req_o,
  input wire logic [NCH-1:0] dma_ack_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  dma_hold_a: assert property (
    (~dma_req_o & $past(dma_req_o) & ~$past(dma_ack_i)) == '0)
    else $error("dma request dropped without acceptance");
  dma_rise_a: assert property (
    ((dma_req_o & ~$past(dma_req_o)) != '0) |-> $past(ce_i))
    else $error("dma request raised while halted");
  freeze_a: assert property (
    !ce_i |=> $stable(irq_o) && $stable(dma_req_o) && $stable(s_axi_rvalid_o))
    else $error("outputs moved while halted");
  upper_zero_a: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // Response stands until taken
  b_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response not held");
  r_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  // Read answer one cycle after address
  rd_lat_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o && ce_i |=> s_axi_rvalid_o)
    else $error("read answer late");
  // Write and read channels closed while answering
  w_busy_a: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted during response");
  w_reopen_a: assert property (
    s_axi_bvalid_o && s_axi_bready_i && ce_i |=> s_axi_awready_o && !s_axi_bvalid_o)
    else $error("write channel not reopened");
  r_busy_a: assert property (
    s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted during answer");

  // Main scenarios reached
  cover property ($rose(dma_req_o[1]));
  cover property ($rose(irq_o[0]));
  cover property (s_axi_bvalid_o && s_axi_bresp_o == `IMT_RESP_SLVERR);
endmodule // imt_props

bind imt_top imt_props #(.NCH(NCH)) imt_props_inst (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .irq_o(irq_o), .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i));
`default_nettype wire

// ===== test/imt_dma_model.sv
`timescale 1ns/100ps
`default_nettype none

module imt_dma_model #(
  parameter NCH = 2
) (
  // Clock and reset
  input wire logic           mclk_i,
  input wire logic           rst_b_i,
  // Acceptance delay in cycles
  input wire logic [3:0]     lat_i,
  // Requests in, acceptance out
  input wire logic [NCH-1:0] req_i,
  output logic [NCH-1:0]     ack_o
);
  logic [3:0] wait_r [NCH]; // Delay count per channel

  always @(posedge mclk_i) begin
    for (int c = 0; c < NCH; c++) begin
      // One-cycle pulse, then wait for a fresh request
      if (!rst_b_i || !req_i[c] || ack_o[c]) begin
        ack_o[c] <= 1'b0;
        wait_r[c] <= 4'h0;
      end else if (wait_r[c] == lat_i) begin
        ack_o[c] <= 1'b1;
      end else begin
        wait_r[c] <= wait_r[c] + 4'h1;
      end
    end
  end
endmodule // imt_dma_model
`default_nettype wire

// ===== test/test_interval_match_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "imt_defs.vh"

module test_interval_match_timer;
  // Clock and control
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  // Bus master side
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] dma_lat = 4'h0;
  // Design outputs
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, irq, dma_req, dma_ack;
  logic [31:0] rdata;
  // Verdict counters
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] d;
  logic [1:0] r;

  always #2 mclk_i = ~mclk_i;

  imt_top #(.ADDR_W(8), .CNT_W(16), .NCH(2)) imt_top_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h3), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .irq_o(irq),
    .dma_req_o(dma_req), .dma_ack_i(dma_ack));

  imt_dma_model #(.NCH(2)) imt_dma_model_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .lat_i(dma_lat),
    .req_i(dma_req), .ack_o(dma_ack));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Byte address of a channel register
  function automatic logic [7:0] ad(input int c, input logic [3:0] o);
    return {3'b000, c[0], o};
  endfunction

  // One write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // One read; count is latched one edge after setup
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[15:0];
    r = rresp;
    rready <= 1'b0;
  endtask

  // Counter advance over exactly 128 cycles
  task automatic meas(input int c, output logic [15:0] dl);
    logic [15:0] a;
    rd(ad(c, `IMT_OFS_CNT));
    a = d;
    repeat (125) @(posedge mclk_i);
    rd(ad(c, `IMT_OFS_CNT));
    dl = d - a;
  endtask

  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      rd(ad(c, `IMT_OFS_RUN));
      chk("run_rst", d, `IMT_RST_RUN);
      rd(ad(c, `IMT_OFS_CSR));
      chk("csr_rst", d, `IMT_RST_CSR);
      rd(ad(c, `IMT_OFS_LIM));
      chk("lim_rst", d, `IMT_RST_LIM);
    end
  endtask

  // Reserved bits, write-one on flag, unmapped place
  task automatic t_rsvd();
    wr(ad(1, `IMT_OFS_RUN), 16'hFFFF);
    rd(ad(1, `IMT_OFS_RUN));
    chk("run_rsvd", d, 32'h0000_0001);
    wr(ad(1, `IMT_OFS_RUN), 16'h0000);
    wr(ad(1, `IMT_OFS_CSR), 16'hFFFF);
    rd(ad(1, `IMT_OFS_CSR));
    chk("csr_rsvd", d, 32'h0000_0033);
    wr(ad(1, `IMT_OFS_CSR), 16'h0000);
    rd(8'h20);
    chk("unm_rresp", r, `IMT_RESP_SLVERR);
    chk("unm_rdata", d, 32'h0000_0000);
    wr(8'hE0, 16'h1234);
    chk("unm_bresp", r, `IMT_RESP_SLVERR);
  endtask

  // Every divider on both channels, then held
  task automatic t_tick();
    int dv [4] = '{`IMT_DIV_A, `IMT_DIV_B, `IMT_DIV_C, `IMT_DIV_D};
    logic [15:0] dl;
    for (int c = 0; c < 2; c++) begin
      wr(ad(c, `IMT_OFS_RUN), 16'h0001);
      for (int s = 0; s < 4; s++) begin
        wr(ad(c, `IMT_OFS_CSR), {14'h0000, s[1:0]});
        meas(c, dl);
        chk("tick_rate", dl, 128 / dv[s]);
      end
      wr(ad(c, `IMT_OFS_RUN), 16'h0000);
      meas(c, dl);
      chk("held", dl, 32'h0000_0000);
    end
  endtask

  // Match in interrupt mode and flag clearing
  task automatic t_match();
    wr(ad(0, `IMT_OFS_LIM), 16'h0005);
    wr(ad(0, `IMT_OFS_CNT), 16'h0005);
    wr(ad(0, `IMT_OFS_CSR), 16'h0023);
    repeat (70) @(posedge mclk_i);
    rd(ad(0, `IMT_OFS_CSR));
    chk("no_tick_flag", d, 32'h0000_0023);
    wr(ad(0, `IMT_OFS_RUN), 16'h0001);
    repeat (70) @(posedge mclk_i);
    rd(ad(0, `IMT_OFS_CNT));
    chk("wrap_zero", d <= 16'h0001, 1'b1);
    chk("irq_on", irq[0], 1'b1);
    wr(ad(0, `IMT_OFS_RUN), 16'h0000);
    wr(ad(0, `IMT_OFS_CSR), 16'h00A3);
    wr(ad(0, `IMT_OFS_CSR), 16'h0023);
    rd(ad(0, `IMT_OFS_CSR));
    chk("flag_kept", d, 32'h0000_00A3);
    wr(ad(0, `IMT_OFS_CSR), 16'h0023);
    rd(ad(0, `IMT_OFS_CSR));
    chk("flag_clr", d, 32'h0000_0023);
    chk("irq_off", irq[0], 1'b0);
  endtask

  // Transfer requests, prompt and slow acceptance
  task automatic t_dma();
    int n;
    wr(ad(1, `IMT_OFS_LIM), 16'h0001);
    wr(ad(1, `IMT_OFS_CSR), 16'h0010);
    // Start below the limit, else the count climbs to wrap first
    wr(ad(1, `IMT_OFS_CNT), 16'h0000);
    for (int l = 0; l < 2; l++) begin
      dma_lat <= l ? 4'h4 : 4'h0;
      wr(ad(1, `IMT_OFS_RUN), 16'h0001);
      n = 0;
      while (dma_req[1] !== 1'b1 && n < 100) begin
        @(posedge mclk_i);
        n++;
      end
      wr(ad(1, `IMT_OFS_RUN), 16'h0000);
      chk("dma_seen", n < 100, 1'b1);
      repeat (12) @(posedge mclk_i);
      chk("dma_gone", dma_req[1], 1'b0);
      rd(ad(1, `IMT_OFS_CSR));
      chk("dma_flag", d, 32'h0000_0090);
    end
    for (int m = 0; m < 4; m += 3) begin
      wr(ad(1, `IMT_OFS_CSR), {10'h000, m[1:0], 4'h0});
      wr(ad(1, `IMT_OFS_RUN), 16'h0001);
      repeat (40) @(posedge mclk_i);
      chk("no_irq", irq[1], 1'b0);
      chk("no_dma", dma_req[1], 1'b0);
      wr(ad(1, `IMT_OFS_RUN), 16'h0000);
    end
  endtask

  // Halted clock stops counting
  task automatic t_halt();
    logic [15:0] a;
    wr(ad(0, `IMT_OFS_LIM), 16'hFFFF);
    wr(ad(0, `IMT_OFS_CSR), 16'h0000);
    wr(ad(0, `IMT_OFS_RUN), 16'h0001);
    rd(ad(0, `IMT_OFS_CNT));
    a = d;
    ce_i <= 1'b0;
    repeat (100) @(posedge mclk_i);
    ce_i <= 1'b1;
    rd(ad(0, `IMT_OFS_CNT));
    chk("halt", (d - a) <= 16'h0001, 1'b1);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_rsvd();
    t_tick();
    t_match();
    t_dma();
    t_halt();
    close_out();
  end
endmodule // test_interval_match_timer
`default_nettype wire
